// ==== hw/fac_core.v ====
// Fault address capture: memory fault and bus fault address registers,
// valid flags, vector read fault flag, interrupt, APB slave.
// Assumes the fault path is synchronous to ref_clk_i; the privilege
// strap pprot[0] of APB marks privileged access.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "fac_map.vh"
module fac_core (
  input wire ref_clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [2:0] pprot_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire mem_fault_i,
  input wire [31:0] mem_sub_addr_i,
  input wire bus_fault_i,
  input wire [31:0] bus_req_addr_i,
  input wire vect_read_i,
  input wire ext_hold_i,
  output reg hard_fault_o,
  output reg irq_o,
  output reg hold_o
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [31:0] mem_addr_reg;
  reg [31:0] mem_addr_next;
  reg [31:0] bus_addr_reg;
  reg [31:0] bus_addr_next;
  reg [`FAC_STAT_W-1:0] stat_reg;
  reg [`FAC_STAT_W-1:0] stat_next;
  reg [`FAC_STAT_W-1:0] mask_reg;
  reg [`FAC_STAT_W-1:0] mask_next;
  wire hold_sync;
  reg [`FAC_STAT_W-1:0] set_bits;
  reg [`FAC_STAT_W-1:0] clr_bits;
  reg irq_next;
  reg hard_fault_next;
  reg hold_next;
  reg pready_next;
  reg pslverr_next;
  reg [31:0] prdata_next;
  integer i;
  localparam PAD_W = 32 - `FAC_STAT_W;

  // ------------------------------------------------------------
  // Debug hold input from a pin
  // ------------------------------------------------------------
  fac_sync u_hold_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(ext_hold_i),
    .q_o(hold_sync)
  );

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function is_reg;
    input [11:0] a;
    begin
      is_reg = hit(a, `FAC_OFF_MEM_ADDR) || hit(a, `FAC_OFF_BUS_ADDR) ||
               hit(a, `FAC_OFF_STATUS) || hit(a, `FAC_OFF_IRQ_MASK);
    end
  endfunction

  // Hardware set beats a same-cycle clear
  function sticky;
    input cur;
    input clr;
    input set;
    begin
      sticky = set || (cur && !clr);
    end
  endfunction

  function [31:0] read_word;
    input [11:0] a;
    input [31:0] m;
    input [31:0] b;
    input [`FAC_STAT_W-1:0] s;
    input [`FAC_STAT_W-1:0] k;
    begin
      case (a)
        `FAC_OFF_MEM_ADDR: read_word = m;
        `FAC_OFF_BUS_ADDR: read_word = b;
        `FAC_OFF_STATUS: read_word = {{PAD_W{1'b0}}, s};
        `FAC_OFF_IRQ_MASK: read_word = {{PAD_W{1'b0}}, k};
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire priv = pprot_i[0];
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i && pready_o;
  wire allowed = priv && is_reg(paddr_i);
  wire wr = access && allowed && pwrite_i;
  wire rd_setup = setup && priv && !pwrite_i;
  wire wr_mem = wr && hit(paddr_i, `FAC_OFF_MEM_ADDR);
  wire wr_bus = wr && hit(paddr_i, `FAC_OFF_BUS_ADDR);
  wire wr_stat = wr && hit(paddr_i, `FAC_OFF_STATUS);
  wire wr_mask = wr && hit(paddr_i, `FAC_OFF_IRQ_MASK);

  // ------------------------------------------------------------
  // Fault inputs
  // ------------------------------------------------------------
  wire bus_vect = bus_fault_i && vect_read_i;

  // ------------------------------------------------------------
  // Memory fault address
  // ------------------------------------------------------------
  // Capture wins over a same-cycle software write
  always @* begin
    mem_addr_next = mem_addr_reg;
    if (mem_fault_i) begin
      mem_addr_next = mem_sub_addr_i;
    end else if (wr_mem) begin
      mem_addr_next = pwdata_i;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_reg <= `FAC_RST_ADDR;
    end else begin
      mem_addr_reg <= mem_addr_next;
    end
  end

  // ------------------------------------------------------------
  // Bus fault address
  // ------------------------------------------------------------
  // Requested address, not the faulting sub-access
  always @* begin
    bus_addr_next = bus_addr_reg;
    if (bus_fault_i) begin
      bus_addr_next = bus_req_addr_i;
    end else if (wr_bus) begin
      bus_addr_next = pwdata_i;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_addr_reg <= `FAC_RST_ADDR;
    end else begin
      bus_addr_reg <= bus_addr_next;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always @* begin
    set_bits = {`FAC_STAT_W{1'b0}};
    set_bits[`FAC_BIT_MEM_VALID] = mem_fault_i;
    set_bits[`FAC_BIT_BUS_VALID] = bus_fault_i;
    set_bits[`FAC_BIT_VECT] = bus_vect;
  end

  always @* begin
    clr_bits = {`FAC_STAT_W{1'b0}};
    if (wr_stat) begin
      clr_bits = pwdata_i[`FAC_STAT_W-1:0];
    end
  end

  always @* begin
    stat_next = stat_reg;
    for (i = 0; i < `FAC_STAT_W; i = i + 1) begin
      stat_next[i] = sticky(stat_reg[i], clr_bits[i], set_bits[i]);
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= `FAC_RST_STAT;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ------------------------------------------------------------
  // Interrupt mask
  // ------------------------------------------------------------
  always @* begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = pwdata_i[`FAC_STAT_W-1:0];
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= `FAC_RST_MASK;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ------------------------------------------------------------
  // Event outputs
  // ------------------------------------------------------------
  // Interrupt sees the status and mask of this same edge
  always @* begin
    irq_next = |(stat_next & mask_next);
  end

  always @* begin
    hard_fault_next = bus_vect;
  end

  always @* begin
    hold_next = hold_sync;
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hard_fault_o <= 1'b0;
    end else begin
      hard_fault_o <= hard_fault_next;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_o <= 1'b0;
    end else begin
      hold_o <= hold_next;
    end
  end

  // ------------------------------------------------------------
  // APB answer: no wait states, read data registered
  // ------------------------------------------------------------
  always @* begin
    pready_next = setup;
  end

  always @* begin
    pslverr_next = setup && !allowed;
  end

  always @* begin
    prdata_next = 32'h0000_0000;
    if (rd_setup) begin
      prdata_next = read_word(paddr_i, mem_addr_reg, bus_addr_reg, stat_reg, mask_reg);
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= pready_next;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= pslverr_next;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else begin
      prdata_o <= prdata_next;
    end
  end
endmodule

// ==== hw/fac_map.vh ====
// Register map and field constants of the fault address capture block.
// Included by the capture core; definitions only.
`ifndef FAC_MAP_VH
`define FAC_MAP_VH

`define FAC_OFF_MEM_ADDR 12'hd34
`define FAC_OFF_BUS_ADDR 12'hd38
`define FAC_OFF_STATUS 12'hd3c
`define FAC_OFF_IRQ_MASK 12'hd40

`define FAC_BIT_MEM_VALID 0
`define FAC_BIT_BUS_VALID 1
`define FAC_BIT_VECT 2
`define FAC_STAT_W 3

`define FAC_RST_ADDR 32'h0000_0000
`define FAC_RST_STAT 3'h0
`define FAC_RST_MASK 3'h0

`endif

// ==== hw/fac_sync.v ====
// Two-flop synchroniser for one level crossing into ref_clk_i.
// Assumes the source is asynchronous to ref_clk_i.
`timescale 1ns/1ps
module fac_sync (
  input wire ref_clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

// ==== verification/fac_core_properties.sv ====
// Checker of the fac_core ports.
// Assumes a bind onto fac_core.
`timescale 1ns/1ps
module fac_core_properties (
  input wire ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire mem_fault_i, bus_fault_i, vect_read_i, ext_hold_i, hard_fault_o, irq_o, hold_o,
  input wire [11:0] paddr_i,
  input wire [2:0] pprot_i,
  input wire [31:0] pwdata_i, prdata_o, mem_sub_addr_i, bus_req_addr_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  reg [31:0] ma, ba;
  reg mv, bv;
  wire wr = psel_i && penable_i && pwrite_i && pready_o && pprot_i[0];
  wire clr = wr && paddr_i == 12'hd3c;
  wire rd = psel_i && penable_i && !pwrite_i && pready_o && pprot_i[0];
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {mv, bv, ma, ba} <= 66'h0;
    end else begin
      mv <= mem_fault_i | (mv & !(clr & pwdata_i[0]));
      bv <= bus_fault_i | (bv & !(clr & pwdata_i[1]));
      if (mem_fault_i) ma <= mem_sub_addr_i;
      else if (wr && paddr_i == 12'hd34) ma <= pwdata_i;
      if (bus_fault_i) ba <= bus_req_addr_i;
      else if (wr && paddr_i == 12'hd38) ba <= pwdata_i;
    end
  end
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  a_ready_wait: assert property (s_setup |=> pready_o) else $error("no ready");
  a_mem_addr: assert property (rd && paddr_i == 12'hd34
    |-> prdata_o == $past(ma)) else $error("mem address");
  a_bus_addr: assert property (rd && paddr_i == 12'hd38
    |-> prdata_o == $past(ba)) else $error("bus address");
  a_mem_valid: assert property (rd && paddr_i == 12'hd3c && $past(mv)
    |-> prdata_o[0]) else $error("mem valid");
  a_bus_valid: assert property (rd && paddr_i == 12'hd3c && $past(bv)
    |-> prdata_o[1]) else $error("bus valid");
  a_priv_refuse: assert property (pready_o && !pprot_i[0]
    |-> pslverr_o && prdata_o == 32'h0) else $error("unprivileged");
  a_vect_hard: assert property (bus_fault_i && vect_read_i |=> hard_fault_o)
    else $error("no hard fault");
  a_hard_cause: assert property (hard_fault_o |-> $past(bus_fault_i && vect_read_i))
    else $error("stray hard fault");
endmodule

// ==== verification/fac_fault_src.sv ====
// Fault path model: raises one-cycle fault pulses.
// Assumes the bench calls fire.
`timescale 1ns/1ps
module fac_fault_src (
  input wire ref_clk_i,
  output reg mem_fault_o = 0, bus_fault_o = 0, vect_read_o = 0,
  output reg [31:0] mem_sub_addr_o = 0, bus_req_addr_o = 0
);
  task fire(input [1:0] k, input [31:0] req);
    @(posedge ref_clk_i);
    mem_fault_o <= !k[0];
    bus_fault_o <= k[0];
    vect_read_o <= k[1];
    mem_sub_addr_o <= (req & ~32'h3) + 32'h4;
    bus_req_addr_o <= req;
    @(posedge ref_clk_i);
    {mem_fault_o, bus_fault_o, vect_read_o} <= 3'h0;
    mem_sub_addr_o <= ~mem_sub_addr_o;
    bus_req_addr_o <= ~bus_req_addr_o;
  endtask
endmodule

// ==== verification/test_fac_core.sv ====
// Bench of fac_core: APB calls and fault scenarios.
// Assumes fac_fault_src as the fault path.
`timescale 1ns/1ps
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h", $time, a); end end
module test_fac_core;
  reg ref_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e, hold_pin = 0;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0, q;
  reg [2:0] pprot_i = 0;
  wire [31:0] prdata_o, msa, bra;
  wire pready_o, pslverr_o, mf, bf, vr, hard_fault_o, irq_o, hold_o;
  integer error_cnt = 0, check_count = 0, cyc = 0;
  fac_core fac_core_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pprot_i(pprot_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mem_fault_i(mf), .mem_sub_addr_i(msa), .bus_fault_i(bf), .bus_req_addr_i(bra),
    .vect_read_i(vr), .ext_hold_i(hold_pin), .hard_fault_o(hard_fault_o), .irq_o(irq_o),
    .hold_o(hold_o));
  fac_fault_src fac_fault_src_i (.ref_clk_i(ref_clk_i), .mem_fault_o(mf),
    .bus_fault_o(bf), .vect_read_o(vr), .mem_sub_addr_o(msa), .bus_req_addr_o(bra));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results;
    end
  end
  task results;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input p);
    @(posedge ref_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pprot_i} <= {2'h2, w, a, d, 2'h0, p};
    @(posedge ref_clk_i);
    penable_i <= 1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    {e, q} = {pslverr_o, prdata_o};
    {psel_i, penable_i} <= 2'h0;
    #1;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 0;
    apb(0, 12'hd3c, 0, 1); `CK({e, q}, 33'h0)
    fac_fault_src_i.fire(0, 32'h2000_0102);
    apb(0, 12'hd34, 0, 1); `CK(q, 32'h2000_0104)
    fac_fault_src_i.fire(3, 32'h3000_0006);
    #1 `CK(hard_fault_o, 1'b1)
    apb(0, 12'hd38, 0, 1); `CK(q, 32'h3000_0006)
    apb(0, 12'hd3c, 0, 1); `CK(q, 32'h7)
    apb(1, 12'hd40, 7, 1); `CK(irq_o, 1'b1)
    apb(1, 12'hd3c, 7, 1); `CK(irq_o, 1'b0)
    $display("faults done");
    apb(0, 12'hd38, 0, 0); `CK({e, q}, 33'h1_0000_0000)
    apb(1, 12'hd34, 9, 0); apb(0, 12'hd34, 0, 1); `CK(q, 32'h2000_0104)
    apb(1, 12'hd34, 9, 1); apb(0, 12'hd34, 0, 1); `CK(q, 32'h9)
    apb(0, 12'hd44, 0, 1); `CK(e, 1'b1)
    $display("access done");
    @(posedge ref_clk_i);
    hold_pin <= 1;
    repeat (2) @(posedge ref_clk_i);
    #1 `CK(hold_o, 1'b0)
    @(posedge ref_clk_i);
    #1 `CK(hold_o, 1'b1)
    $display("hold done");
    results;
  end
endmodule
bind fac_core fac_core_properties fac_core_properties_i (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_fault_i(mem_fault_i),
  .bus_fault_i(bus_fault_i), .vect_read_i(vect_read_i), .ext_hold_i(ext_hold_i),
  .hard_fault_o(hard_fault_o), .irq_o(irq_o), .hold_o(hold_o), .paddr_i(paddr_i),
  .pprot_i(pprot_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .mem_sub_addr_i(mem_sub_addr_i), .bus_req_addr_i(bus_req_addr_i));
